/* File: verilog/dsomp_pkg.sv */
// dsomp_pkg: constants, field positions and carrier types of the data-side
// on-chip memory port. Assumes one memory-side clock and little-endian vectors
// (processor bit 0 is the most significant bit of a 32-bit address).
// Overview of operation
// - Enable pulses on every read and write.
// - Variable-latency variant: enable high one cycle.
// - Word address is processor bits 8 to 29.
// - Access starts only when top byte matches region.
// - Writes carry byte-lane enables with the address.
// - Variable-latency reads carry read-address-valid strobe.
// - Write data leaves on a 32-bit bus.
// - Write data valid one cycle, lane-qualified.
// - Four independent lanes, lane i governs byte i.
// - Byte enables pulse once; slave uses as qualifier.
// - Read-address-valid pulses one cycle per read.
// - Write-address-valid pulses one cycle per write.
// - Busy output mirrors control register bit two.
// - Earlier variant: no strobes, no completion handshake.
// - Next access may issue after completion.
// - Region register picks the 16 MB window.
package dsomp_pkg;

  localparam int unsigned ADDR_W      = 22;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned LANES       = 4;
  localparam int unsigned LANE_W      = 8;
  localparam int unsigned CPU_ADDR_W  = 32;
  localparam int unsigned WORD_LSB    = 2;   // processor bit 29
  localparam int unsigned WORD_MSB    = 23;  // processor bit 8
  localparam int unsigned REGION_LSB  = 24;  // processor bit 7
  localparam int unsigned REGION_MSB  = 31;  // processor bit 0
  localparam int unsigned REGION_W    = 8;
  localparam int unsigned CTRL_W      = 8;
  localparam int unsigned CTRL_BUSY   = 5;   // control bit 2 counted from the msb

  localparam logic [ADDR_W-1:0] ADDR_RST = 22'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
  localparam logic [LANES-1:0]  LANE_OFF = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT
  } dsomp_state_t;

  // processor-side access request
  typedef struct packed {
    logic                  valid;
    logic                  write;
    logic [CPU_ADDR_W-1:0] addr;
    logic [LANES-1:0]      byteEn;
    logic [DATA_W-1:0]     wdata;
  } dsomp_req_t;

  // processor-side answer
  typedef struct packed {
    logic              valid;
    logic              miss;
    logic [DATA_W-1:0] data;
  } dsomp_rsp_t;

  // signals toward block RAM or the fabric slave
  typedef struct packed {
    logic              memAccessEnable;
    logic [ADDR_W-1:0] memWordAddress;
    logic [DATA_W-1:0] memWriteData;
    logic [LANES-1:0]  byteLaneWriteEnable;
    logic              readAddressValid;
    logic              writeAddressValid;
  } dsomp_mem_t;

  // complete state of the port
  typedef struct packed {
    dsomp_state_t state;
    dsomp_mem_t   mem;
    dsomp_rsp_t   rsp;
    logic         busy;
  } dsomp_regs_t;

endpackage

/* File: verilog/dsomp_region_match.sv */
// dsomp_region_match: decides whether a processor address falls in the
// 16 MB window chosen by the region select value. Pure combinational logic.
`timescale 1ns/1ps
module dsomp_region_match #(
  parameter int unsigned REGION_W = 8
) (
  // compared fields
  input  wire logic [REGION_W-1:0] addrTop,
  input  wire logic [REGION_W-1:0] regionSelect,
  // decision
  output logic                     inRegion
);

  // top byte equality selects one of 256 windows of 16 MB
  assign inRegion = (addrTop == regionSelect);

endmodule

/* File: verilog/dsomp_port.sv */
// dsomp_port: output side of the data-side on-chip memory controller. Takes one
// processor access at a time, drives it toward block RAM or a fabric slave and
// returns the answer. Assumes completion and read data come from logic on mclk.
`timescale 1ns/1ps
module dsomp_port
  import dsomp_pkg::*;
#(
  parameter bit VARIABLE_LATENCY = 1'b1
) (
  // clock, reset, enable
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  input  wire logic                     ce,
  // configuration values
  input  wire logic [dsomp_pkg::REGION_W-1:0] dataRegionSelectReg,
  input  wire logic [dsomp_pkg::CTRL_W-1:0]   dataPortControlReg,
  // processor request and answer
  input  wire dsomp_pkg::dsomp_req_t    req,
  output logic                          reqReady,
  output dsomp_pkg::dsomp_rsp_t         rsp,
  // memory side
  output dsomp_pkg::dsomp_mem_t         mem,
  input  wire logic [dsomp_pkg::DATA_W-1:0]   memReadData,
  input  wire logic                     accessComplete,
  // fabric flag
  output logic                          softwareFlagOut
);
  import dsomp_pkg::*;

  dsomp_regs_t regs_ff;
  dsomp_regs_t nxt_regs;
  logic        inRegion;
  logic        take;
  logic        done;

  // region decode on processor bits 0 to 7
  dsomp_region_match #(
    .REGION_W (REGION_W)
  ) u_region (
    .addrTop      (req.addr[REGION_MSB:REGION_LSB]),
    .regionSelect (dataRegionSelectReg),
    .inRegion     (inRegion)
  );

  // a request is taken only from idle, so one access stays outstanding
  assign reqReady = (regs_ff.state == ST_IDLE);
  assign take     = req.valid && reqReady;

  // fixed latency: data is present the cycle after the enable pulse;
  // variable latency waits for the slave, which must never leave us hanging
  assign done = (regs_ff.state == ST_WAIT) &&
                (VARIABLE_LATENCY ? accessComplete : 1'b1);

  // next-state logic for the whole port
  always_comb begin
    nxt_regs           = regs_ff;
    nxt_regs.busy      = dataPortControlReg[CTRL_BUSY];
    nxt_regs.rsp.valid = 1'b0;
    // strobes are single-cycle: cleared unless this cycle issues
    nxt_regs.mem.memAccessEnable     = 1'b0;
    nxt_regs.mem.byteLaneWriteEnable = LANE_OFF;
    nxt_regs.mem.readAddressValid    = 1'b0;
    nxt_regs.mem.writeAddressValid   = 1'b0;
    unique case (regs_ff.state)
      ST_IDLE: begin
        if (take && inRegion) begin
          nxt_regs.state                = ST_ISSUE;
          nxt_regs.mem.memAccessEnable  = 1'b1;
          nxt_regs.mem.memWordAddress   = req.addr[WORD_MSB:WORD_LSB];
          nxt_regs.rsp.miss             = 1'b0;
          if (req.write) begin
            nxt_regs.mem.memWriteData        = req.wdata;
            nxt_regs.mem.byteLaneWriteEnable = req.byteEn;
            nxt_regs.mem.writeAddressValid   = VARIABLE_LATENCY;
          end else begin
            nxt_regs.mem.readAddressValid    = VARIABLE_LATENCY;
          end
        end else if (take) begin
          // outside the window: answered at once, memory untouched
          nxt_regs.rsp.valid = 1'b1;
          nxt_regs.rsp.miss  = 1'b1;
          nxt_regs.rsp.data  = DATA_RST;
        end
      end
      ST_ISSUE: begin
        nxt_regs.state = ST_WAIT;
      end
      ST_WAIT: begin
        if (done) begin
          nxt_regs.state     = ST_IDLE;
          nxt_regs.rsp.valid = 1'b1;
          nxt_regs.rsp.data  = memReadData;
        end
      end
      default: nxt_regs.state = ST_IDLE; // unused code falls back to idle, no lockup
    endcase
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regs_ff.state                   <= ST_IDLE;
      regs_ff.mem.memAccessEnable     <= 1'b0;
      regs_ff.mem.memWordAddress      <= ADDR_RST;
      regs_ff.mem.memWriteData        <= DATA_RST;
      regs_ff.mem.byteLaneWriteEnable <= LANE_OFF;
      regs_ff.mem.readAddressValid    <= 1'b0;
      regs_ff.mem.writeAddressValid   <= 1'b0;
      regs_ff.rsp.valid               <= 1'b0;
      regs_ff.rsp.miss                <= 1'b0;
      regs_ff.rsp.data                <= DATA_RST;
      regs_ff.busy                    <= 1'b0;
    end else if (ce) begin
      regs_ff <= nxt_regs;
    end
  end

  assign mem             = regs_ff.mem;
  assign rsp             = regs_ff.rsp;
  assign softwareFlagOut = regs_ff.busy;

  // enable never lasts beyond one active cycle
  a_enable_one_cycle: assert property (@(posedge mclk) disable iff (sys_rst)
    (mem.memAccessEnable && ce) |=> !mem.memAccessEnable)
    else $error("memory enable held longer than one cycle");

  // word address is the matching processor field of the taken request
  a_word_addr_map: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && inRegion && ce) |=>
      (mem.memWordAddress == $past(req.addr[WORD_MSB:WORD_LSB])) && mem.memAccessEnable)
    else $error("word address does not match request");

  // an address outside the window never reaches memory
  a_region_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && !inRegion && ce) |=> !mem.memAccessEnable && rsp.valid && rsp.miss)
    else $error("out-of-region access reached memory");

  // read strobe only with enable and with lanes off
  a_read_strobe: assert property (@(posedge mclk) disable iff (sys_rst)
    mem.readAddressValid |->
      mem.memAccessEnable && (mem.byteLaneWriteEnable == LANE_OFF) && !mem.writeAddressValid)
    else $error("read strobe without enable or with lanes set");

  // write strobe accompanies the enable and the lanes of the request
  a_write_strobe: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && inRegion && req.write && ce) |=>
      (mem.writeAddressValid == VARIABLE_LATENCY) &&
      (mem.byteLaneWriteEnable == $past(req.byteEn)) &&
      (mem.memWriteData == $past(req.wdata)))
    else $error("write strobe, lanes or data wrong");

  // lanes stay low whenever no access is on the bus
  a_lanes_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    !mem.memAccessEnable |-> (mem.byteLaneWriteEnable == LANE_OFF))
    else $error("byte lanes active outside an access");

  // nothing new goes out while one access is pending
  a_one_outstanding: assert property (@(posedge mclk) disable iff (sys_rst)
    (regs_ff.state == ST_WAIT) |-> !mem.memAccessEnable && !reqReady)
    else $error("second access issued while one outstanding");

  // busy output follows the control bit one active cycle later
  a_busy_mirror: assert property (@(posedge mclk) disable iff (sys_rst)
    ce |=> (softwareFlagOut == $past(dataPortControlReg[CTRL_BUSY])))
    else $error("busy output does not mirror control bit");

  // completion in wait answers with the read data and frees the port
  a_complete_answer: assert property (@(posedge mclk) disable iff (sys_rst)
    (done && ce) |=> rsp.valid && reqReady && (rsp.data == $past(memReadData)))
    else $error("completion not answered");

  // the earlier variant never drives the address strobes
  a_variant_strobes: assert property (@(posedge mclk) disable iff (sys_rst)
    !VARIABLE_LATENCY |-> !mem.readAddressValid && !mem.writeAddressValid)
    else $error("address strobe in fixed-latency variant");

  // a taken read goes out with its enable, its strobe and every lane low
  a_read_issue: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && inRegion && !req.write && ce) |=>
      mem.memAccessEnable && (mem.readAddressValid == VARIABLE_LATENCY) &&
      (mem.byteLaneWriteEnable == LANE_OFF))
    else $error("read issued without enable or strobe");

  // lanes qualify write data for one active cycle only
  a_lane_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
    ((mem.byteLaneWriteEnable != LANE_OFF) && ce) |=> (mem.byteLaneWriteEnable == LANE_OFF))
    else $error("byte lanes held longer than one cycle");

  // single-cycle read strobe, so a slave may count strobes as accesses
  a_read_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
    (mem.readAddressValid && ce) |=> !mem.readAddressValid)
    else $error("read strobe held longer than one cycle");

  // single-cycle write strobe for the same reason
  a_write_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
    (mem.writeAddressValid && ce) |=> !mem.writeAddressValid)
    else $error("write strobe held longer than one cycle");

  // a write strobe always travels with the enable, never with a read strobe
  a_write_qualify: assert property (@(posedge mclk) disable iff (sys_rst)
    mem.writeAddressValid |-> mem.memAccessEnable && !mem.readAddressValid)
    else $error("write strobe without enable");

  // once an access is on the bus the port refuses the next request
  a_issue_holds: assert property (@(posedge mclk) disable iff (sys_rst)
    (mem.memAccessEnable && ce) |=> !reqReady)
    else $error("request accepted while an access is on the bus");

  // fixed latency: the answer comes two active cycles after the enable
  a_fixed_latency: assert property (@(posedge mclk) disable iff (sys_rst)
    (!VARIABLE_LATENCY && mem.memAccessEnable && ce) ##1 ce |=> rsp.valid)
    else $error("fixed-latency answer late");

  // a low clock enable holds every flop, strobes included
  a_ce_freeze: assert property (@(posedge mclk) disable iff (sys_rst)
    !ce |=> (regs_ff == $past(regs_ff)))
    else $error("state moved while clock enable low");

  // reset leaves the bus quiet and the port ready
  a_reset_quiet: assert property (@(posedge mclk)
    sys_rst |=> !mem.memAccessEnable && !rsp.valid && reqReady && !softwareFlagOut &&
      (mem.byteLaneWriteEnable == LANE_OFF))
    else $error("outputs active after reset");

endmodule

/* File: verification/dsomp_slave_model.sv */
// dsomp_slave_model: fabric slave with a variable wait, answering each access once.
// Assumes mclk is shared with dsomp_port. With BLOCK_RAM set it acts as plain block RAM
// behind a fixed-latency port: completion held high, address strobes unread.
`timescale 1ns/1ps
module dsomp_slave_model
  import dsomp_pkg::*;
#(
  parameter bit BLOCK_RAM = 1'b0
) (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  // port side
  input  wire dsomp_pkg::dsomp_mem_t   mem,
  input  wire logic [3:0]              waitCycles,
  output logic [dsomp_pkg::DATA_W-1:0] memReadData,
  output logic                         accessComplete
);
  logic [DATA_W-1:0] store [16];
  logic [3:0]        wordSel_ff;
  logic [3:0]        cnt_ff;
  logic              rd_ff;
  logic              pend_ff;
  // read strobe and address are registered because the answer may come many cycles later
  always_ff @(posedge mclk) begin
    accessComplete <= BLOCK_RAM;
    memReadData    <= ~memReadData; // read data is not valid outside the answer cycle
    if (sys_rst) begin
      pend_ff     <= 1'b0;
      memReadData <= 32'hA5A5A5A5;
    end else if (BLOCK_RAM) begin
      // plain block ram: the enable alone qualifies the address, data one cycle later
      if (mem.memAccessEnable) begin
        if (mem.byteLaneWriteEnable == 4'h0) memReadData <= store[mem.memWordAddress[3:0]];
        for (int i = 0; i < 4; i++) begin
          if (mem.byteLaneWriteEnable[i]) begin
            store[mem.memWordAddress[3:0]][8*i +: 8] <= mem.memWriteData[8*i +: 8];
          end
        end
      end
    end else if (mem.memAccessEnable) begin
      wordSel_ff <= mem.memWordAddress[3:0];
      rd_ff      <= mem.readAddressValid;
      cnt_ff     <= waitCycles;
      pend_ff    <= 1'b1;
      for (int i = 0; i < 4; i++) begin
        if (mem.writeAddressValid && mem.byteLaneWriteEnable[i]) begin
          store[mem.memWordAddress[3:0]][8*i +: 8] <= mem.memWriteData[8*i +: 8];
        end
      end
    end else if (pend_ff && cnt_ff == 4'h0) begin
      accessComplete <= 1'b1;
      pend_ff        <= 1'b0;
      if (rd_ff) memReadData <= store[wordSel_ff];
    end else if (pend_ff) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule

/* File: verification/dsomp_port_tb.sv */
// dsomp_port_tb: hand-written scenarios for dsomp_port against a slow slave model.
// Runs a variable-latency build on a slow slave and a fixed-latency build on block RAM;
// inputs change at the falling edge of mclk.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin errTotal++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module dsomp_port_tb;
  import dsomp_pkg::*;
  logic        mclk, sys_rst, ce, reqReady, accessComplete, flag;
  logic [7:0]  regionSel, ctrl;
  logic [3:0]  waitCycles;
  logic [31:0] rdata, lastData;
  dsomp_req_t  req;
  dsomp_rsp_t  rsp;
  dsomp_mem_t  mem;
  int          errTotal, testsRun, enCount, e;
  logic        fixReady, fixComplete, fixFlag;
  logic [31:0] fixData;
  dsomp_req_t  fixReq;
  dsomp_rsp_t  fixRsp;
  dsomp_mem_t  fixMem;
  dsomp_port dut_u (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .dataRegionSelectReg(regionSel),
    .dataPortControlReg(ctrl), .req(req), .reqReady(reqReady), .rsp(rsp), .mem(mem),
    .memReadData(rdata), .accessComplete(accessComplete), .softwareFlagOut(flag));
  dsomp_slave_model slave_u (.mclk(mclk), .sys_rst(sys_rst), .mem(mem),
    .waitCycles(waitCycles), .memReadData(rdata), .accessComplete(accessComplete));
  // fixed-latency build on plain block RAM
  dsomp_port #(.VARIABLE_LATENCY(1'b0)) dut_fix_u (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
    .dataRegionSelectReg(regionSel), .dataPortControlReg(ctrl), .req(fixReq),
    .reqReady(fixReady), .rsp(fixRsp), .mem(fixMem), .memReadData(fixData),
    .accessComplete(fixComplete), .softwareFlagOut(fixFlag));
  dsomp_slave_model #(.BLOCK_RAM(1'b1)) ram_u (.mclk(mclk), .sys_rst(sys_rst), .mem(fixMem),
    .waitCycles(4'h0), .memReadData(fixData), .accessComplete(fixComplete));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // counts enable pulses so stray accesses show up
  always @(posedge mclk) if (mem.memAccessEnable === 1'b1) enCount++;
  // one access; the memory side is looked at in the pulse cycle and the one after
  task automatic access(input logic wr, input logic [31:0] addr, input logic [3:0] be,
                        input logic [31:0] wd, input logic hit);
    int n;
    n = 0;
    req = '{valid: 1'b1, write: wr, addr: addr, byteEn: be, wdata: wd};
    while (reqReady !== 1'b1 && n < 50) begin @(negedge mclk); n++; end
    @(negedge mclk);
    req.valid = 1'b0;
    if (hit) begin
      `CHK("enable", 1'b1, mem.memAccessEnable)
      `CHK("word address", addr[23:2], mem.memWordAddress)
      `CHK("lanes", wr ? be : 4'h0, mem.byteLaneWriteEnable)
      `CHK("read valid", ~wr, mem.readAddressValid)
      `CHK("write valid", wr, mem.writeAddressValid)
      `CHK("port busy", 1'b0, reqReady)
      if (wr) `CHK("write data", wd, mem.memWriteData)
      @(negedge mclk);
      `CHK("enable pulse", 1'b0, mem.memAccessEnable)
      `CHK("lane pulse", 4'h0, mem.byteLaneWriteEnable)
    end
    n = 0;
    while (rsp.valid !== 1'b1 && n < 50) begin @(negedge mclk); n++; end
    `CHK("answered", 1'b1, rsp.valid)
    `CHK("port free", 1'b1, reqReady)
    `CHK("miss", ~hit, rsp.miss)
    lastData = rsp.data;
  endtask
  // full write, partial lane write, read back the merged word
  task automatic t_lanes();
    waitCycles = 4'h0;
    access(1'b1, 32'hC3000010, 4'hF, 32'h11223344, 1'b1);
    access(1'b1, 32'hC3000010, 4'h5, 32'hAABBCCDD, 1'b1);
    access(1'b0, 32'hC3000010, 4'h0, 32'h0, 1'b1);
    `CHK("merged word", 32'h11BB33DD, lastData)
  endtask
  // slow slave: one enable only while the answer is pending
  task automatic t_slow();
    waitCycles = 4'h9;
    e = enCount;
    access(1'b0, 32'hC3000010, 4'h0, 32'h0, 1'b1);
    `CHK("one enable", e + 1, enCount)
    `CHK("slow data", 32'h11BB33DD, lastData)
  endtask
  // outside the region nothing reaches memory
  task automatic t_miss();
    e = enCount;
    access(1'b1, 32'h3C000010, 4'hF, 32'h0, 1'b0);
    `CHK("no enable", e, enCount)
    `CHK("miss data", DATA_RST, lastData)
  endtask
  // flag follows control bit five both ways
  task automatic t_flag();
    ctrl = 8'h20;
    repeat (2) @(negedge mclk);
    `CHK("flag set", 1'b1, flag)
    `CHK("fixed flag", 1'b1, fixFlag)
    ctrl = 8'hDF;
    repeat (2) @(negedge mclk);
    `CHK("flag clear", 1'b0, flag)
  endtask
  // clock enable low freezes the flag; raising it lets the flag follow again
  task automatic t_hold();
    ctrl = 8'h20;
    ce   = 1'b0;
    repeat (2) @(negedge mclk);
    `CHK("frozen flag", 1'b0, flag)
    ce = 1'b1;
    repeat (2) @(negedge mclk);
    `CHK("thawed flag", 1'b1, flag)
    ctrl = 8'h00;
  endtask
  // fixed build on block RAM: answer two edges after the pulse, strobes never set
  task automatic t_fixed();
    fixReq = '{valid: 1'b1, write: 1'b1, addr: 32'hC3000020, byteEn: 4'hF, wdata: 32'h5A5A0FF0};
    @(negedge mclk);
    fixReq.valid = 1'b0;
    `CHK("fixed enable", 1'b1, fixMem.memAccessEnable)
    `CHK("fixed strobes", 2'b00, {fixMem.readAddressValid, fixMem.writeAddressValid})
    repeat (2) @(negedge mclk);
    `CHK("fixed write done", 1'b1, fixRsp.valid)
    fixReq = '{valid: 1'b1, write: 1'b0, addr: 32'hC3000020, byteEn: 4'h0, wdata: 32'h0};
    @(negedge mclk);
    fixReq.valid = 1'b0;
    `CHK("fixed read strobe", 1'b0, fixMem.readAddressValid)
    repeat (2) @(negedge mclk);
    `CHK("fixed read done", 1'b1, fixRsp.valid)
    `CHK("fixed read data", 32'h5A5A0FF0, fixRsp.data)
  endtask
  task automatic closeOut();
    $display("checks %0d errors %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // the wait loops in access already give up after 50 cycles; this limit is a second guard on the run
  initial begin
    #20000;
    errTotal++;
    closeOut();
  end
  initial begin
    {errTotal, testsRun, enCount} = '0;
    {sys_rst, ce, regionSel, ctrl, waitCycles} = {1'b1, 1'b1, 8'hC3, 8'h00, 4'h0};
    req = '0;
    fixReq = '0;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    t_lanes();
    t_slow();
    t_miss();
    t_flag();
    t_hold();
    t_fixed();
    closeOut();
  end
endmodule
